// ---- rtl/onm_pkg.sv ----
package onm_pkg;

   // Clock and application loop timing.
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned LOOP_TIME_MS = 1000;
   localparam int unsigned LOOP_CYCLES_DFLT = (CLK_HZ / 1000) * LOOP_TIME_MS;
   localparam int unsigned LOOP_CNT_W = 26;

   // Message header bytes.
   localparam logic [7:0] HDR0_COMMAND = 8'h8A;
   localparam logic [7:0] HDR1_COMMAND = 8'hEA;
   localparam logic [7:0] HDR2_COMMAND = 8'h10;
   localparam logic [7:0] HDR1_FROM_PLATFORM = 8'hEB;
   localparam logic [3:0] TYPE_LOAD_OR_REPORT = 4'hA;
   localparam logic [3:0] TYPE_REQUEST = 4'hB;
   localparam logic [7:0] STATE_OFF_BYTE = 8'h20;
   localparam logic [7:0] STATE_ON_BYTE = 8'hA0;
   localparam logic [7:0] CODE_CHANGE_NOW = 8'h82;
   localparam logic [7:0] CODE_LOW_PRESS = 8'h83;
   localparam logic [7:0] PAYLOAD_DONT_CARE = 8'h00;
   localparam int unsigned HDR0_PRIO_LSB = 4;
   localparam int unsigned STATE_BIT_POS = 7;

   // Payload byte field positions; only the zero value is supported.
   localparam int unsigned PERIOD_LSB = 5;
   localparam int unsigned DUTY_LSB = 3;
   localparam int unsigned CRIT_LSB = 0;

   // Controller registers on APB, byte addresses.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LAST_REPORT = 8'h08;
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_SWITCH_BIT = 1;
   localparam int unsigned CTRL_HOLD_LSB = 8;
   localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_FF03;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Pin vector positions of the synchronised engine inputs.
   localparam int unsigned PIN_W = 5;
   localparam int unsigned PIN_OIL_LIFE = 0;
   localparam int unsigned PIN_RUNNING = 1;
   localparam int unsigned PIN_FAULT = 2;
   localparam int unsigned PIN_SENSOR_LOW = 3;
   localparam int unsigned PIN_SWITCH_LOW = 4;

endpackage

// ---- rtl/onm_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous pins.
module onm_sync
   import onm_pkg::*;
#(
   parameter int unsigned WIDTH = 1
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } onm_sync_t;

   onm_sync_t st;
   onm_sync_t next_st;

   // The first stage feeds only the second stage.
   always_comb
   begin
      next_st.meta = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign sync_out = st.stable;

endmodule

// ---- rtl/onm_press_qual.sv ----
// Qualifies a raw low-pressure level into a notification state.
module onm_press_qual
   import onm_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   input wire logic low_in,
   input wire logic running_in,
   input wire logic fault_in,
   input wire logic [7:0] hold_ticks_in,
   output logic qualified_out
);

   typedef struct packed {
      logic [7:0] cnt;
      logic qual;
   } onm_qual_t;

   onm_qual_t st;
   onm_qual_t next_st;

   // A fault or a stopped engine restarts the count, so no stale low survives.
   always_comb
   begin
      next_st = st;
      if (tick_in)
      begin
         if (running_in && !fault_in && low_in)
         begin
            if (st.cnt >= hold_ticks_in)
               next_st.qual = 1'b1;
            else
               next_st.cnt = st.cnt + 8'd1;
         end
         else
         begin
            next_st.cnt = 8'd0;
            next_st.qual = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign qualified_out = st.qual;

   qual_cause_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(st.qual) |-> $past(running_in) && !$past(fault_in) && $past(low_in))
      else $error("Low pressure qualified without its conditions.");

endmodule

// ---- rtl/onm_engine_ctrl.sv ----
// The register offsets and the APB interface to the registers are this design's own decisions.
module onm_engine_ctrl
   import onm_pkg::*;
#(
   parameter int unsigned LOOP_CYCLES = LOOP_CYCLES_DFLT
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic oil_life_reached_in,
   input wire logic engine_running_in,
   input wire logic press_fault_in,
   input wire logic press_sensor_low_in,
   input wire logic press_switch_low_in,
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output logic [7:0] tx_hdr0_out,
   output logic [7:0] tx_hdr1_out,
   output logic [7:0] tx_hdr2_out,
   output logic [7:0] tx_hdr3_out,
   output logic [7:0] tx_hdr4_out,
   output logic [7:0] tx_payload_byte_out,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_hdr0_in,
   input wire logic [7:0] rx_hdr1_in,
   input wire logic [7:0] rx_hdr2_in,
   input wire logic [7:0] rx_hdr3_in,
   input wire logic [7:0] rx_hdr4_in,
   input wire logic [7:0] rx_payload_byte_in
);

   localparam logic [LOOP_CNT_W-1:0] LOOP_LAST = LOOP_CNT_W'(LOOP_CYCLES - 1);

   typedef struct packed {
      logic [LOOP_CNT_W-1:0] loop_cnt;
      logic tick;
      logic [31:0] ctrl;
      logic [1:0] state;
      logic [1:0] pend;
      logic [1:0] ack;
      logic tx_valid;
      logic [7:0] tx_hdr3;
      logic [7:0] tx_hdr4;
      logic [7:0] disc;
      logic [31:0] last_rpt;
      logic [31:0] rdata;
      logic slverr;
   } onm_main_t;

   onm_main_t st;
   onm_main_t next_st;
   logic [PIN_W-1:0] pins;
   logic lp_qual;
   logic run;
   logic rx_ok;
   logic rx_idx;
   logic is_request;
   logic is_report;
   logic [31:0] status_word;

   ////////////////////////////////////////////////////////////////////////////
   // Engine-side inputs come from pins, so they are synchronised first.
   onm_sync #(
      .WIDTH(PIN_W)
   ) u_sync (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .async_in({press_switch_low_in, press_sensor_low_in, press_fault_in,
                 engine_running_in, oil_life_reached_in}),
      .sync_out(pins)
   );

   // The source select lets one controller serve both sensor and switch engines.
   onm_press_qual u_qual (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(st.tick),
      .low_in(st.ctrl[CTRL_SWITCH_BIT] ? pins[PIN_SWITCH_LOW]
                                       : pins[PIN_SENSOR_LOW]),
      .running_in(pins[PIN_RUNNING]),
      .fault_in(pins[PIN_FAULT]),
      .hold_ticks_in(st.ctrl[CTRL_HOLD_LSB +: 8]),
      .qualified_out(lp_qual)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receive decode of the notification codes handled here.
   always_comb
   begin
      run = st.ctrl[CTRL_RUN_BIT];
      rx_ok = (rx_hdr4_in == CODE_CHANGE_NOW) || (rx_hdr4_in == CODE_LOW_PRESS);
      rx_idx = (rx_hdr4_in == CODE_LOW_PRESS);
      is_request = (rx_hdr0_in[3:0] == TYPE_REQUEST) && (rx_hdr1_in == HDR1_FROM_PLATFORM)
                   && (rx_hdr3_in == STATE_OFF_BYTE);
      is_report = (rx_hdr0_in[3:0] == TYPE_LOAD_OR_REPORT)
                  && (rx_hdr1_in == HDR1_FROM_PLATFORM);
      // Status word: discard count in bits 15:8, then transmit, pending, ack and state
      // pairs below it; bit 7 is spare and reads as zero.
      status_word = {16'h0000, st.disc, 1'b0, st.tx_valid, st.pend, st.ack, st.state};
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: loop timer, evaluation, receive, transmit and APB.
   always_comb
   begin
      logic [1:0] eval;
      logic [1:0] set_pend;
      logic [1:0] clr_pend;
      logic [1:0] set_ack;
      logic [1:0] clr_ack;
      logic tx_idx;
      eval = st.state;
      set_pend = 2'b00;
      clr_pend = 2'b00;
      set_ack = 2'b00;
      clr_ack = 2'b00;
      tx_idx = 1'b0;
      next_st = st;
      next_st.tick = 1'b0;
      // Free-running one-second application loop.
      if (st.loop_cnt == LOOP_LAST)
      begin
         next_st.loop_cnt = '0;
         next_st.tick = 1'b1;
      end
      else
         next_st.loop_cnt = st.loop_cnt + LOOP_CNT_W'(1);
      // Evaluation once per loop; a changed state queues a command.
      if (st.tick && run)
      begin
         eval[0] = pins[PIN_OIL_LIFE];
         eval[1] = lp_qual;
         set_pend = eval ^ st.state;
         next_st.state = eval;
      end
      // Messages from the platform are acted on only in Run mode.
      if (rx_valid_in && run)
      begin
         if (rx_hdr0_in[HDR0_PRIO_LSB])
         begin
            if (st.disc != 8'hFF)
               next_st.disc = st.disc + 8'd1;
         end
         else if (rx_ok && is_request)
            set_pend[rx_idx] = 1'b1;
         else if (rx_ok && is_report)
         begin
            next_st.last_rpt = {rx_hdr0_in, rx_hdr2_in, rx_hdr3_in, rx_hdr4_in};
            // Receipt of the latest command is all that is checked.
            if (rx_hdr3_in[STATE_BIT_POS] == st.state[rx_idx])
               set_ack[rx_idx] = 1'b1;
         end
      end
      // Transmit one command at a time; change-now wins a tie.
      // Header bytes are registered with the valid, so they hold while the network stalls.
      if (st.tx_valid && tx_ready_in)
         next_st.tx_valid = 1'b0;
      else if (!st.tx_valid && run && (|st.pend))
      begin
         tx_idx = !st.pend[0];
         clr_pend[tx_idx] = 1'b1;
         clr_ack[tx_idx] = 1'b1;
         next_st.tx_valid = 1'b1;
         next_st.tx_hdr3 = st.state[tx_idx] ? STATE_ON_BYTE : STATE_OFF_BYTE;
         next_st.tx_hdr4 = tx_idx ? CODE_LOW_PRESS : CODE_CHANGE_NOW;
      end
      // A set arriving with a clear wins, so no change is ever dropped.
      next_st.pend = (st.pend & ~clr_pend) | set_pend;
      next_st.ack = (st.ack & ~clr_ack) | set_ack;
      // APB read data is captured in the setup cycle.
      if (psel_in && !penable_in)
      begin
         next_st.slverr = 1'b0;
         unique case (paddr_in)
            REG_CTRL: next_st.rdata = st.ctrl;
            REG_STATUS: next_st.rdata = status_word;
            REG_LAST_REPORT: next_st.rdata = st.last_rpt;
            default:
            begin
               next_st.rdata = 32'h0000_0000;
               next_st.slverr = 1'b1;
            end
         endcase
      end
      // The write lands at the access edge; unmapped control bits are masked to zero.
      if (psel_in && penable_in && pwrite_in && (paddr_in == REG_CTRL))
         next_st.ctrl = pwdata_in & CTRL_WRITE_MASK;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st <= '0;
      end
      else
         st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; fixed header bytes and the zero payload are constants.
   assign pready_out = psel_in && penable_in;
   assign prdata_out = st.rdata;
   assign pslverr_out = psel_in && penable_in && st.slverr;
   assign tx_valid_out = st.tx_valid;
   assign tx_hdr0_out = HDR0_COMMAND;
   assign tx_hdr1_out = HDR1_COMMAND;
   assign tx_hdr2_out = HDR2_COMMAND;
   assign tx_hdr3_out = st.tx_hdr3;
   assign tx_hdr4_out = st.tx_hdr4;
   assign tx_payload_byte_out = PAYLOAD_DONT_CARE;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the command stream and message handling.
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   payload_zero_a: assert property (tx_valid_out |-> tx_payload_byte_out == 8'h00)
      else $error("Command payload byte is not zero.");
   state_byte_a: assert property (tx_valid_out |->
      (tx_hdr3_out == 8'h20) || (tx_hdr3_out == 8'hA0))
      else $error("Command state byte is not 20 or A0.");
   code_header_a: assert property (tx_valid_out |-> tx_hdr1_out == 8'hEA &&
      (tx_hdr4_out == 8'h82 || tx_hdr4_out == 8'h83))
      else $error("Command header carries a wrong code.");
   tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_hdr3_out) && $stable(tx_hdr4_out))
      else $error("Command withdrawn or changed before it was taken.");
   odd_discard_a: assert property (rx_valid_in && run && rx_hdr0_in[4] && st.disc != 8'hFF
      |=> st.disc == $past(st.disc) + 8'd1 && (st.ack & ~$past(st.ack)) == 2'b00)
      else $error("Odd-priority message was not discarded.");
   request_answer_a: assert property (rx_valid_in && run && !rx_hdr0_in[4] && rx_ok
      && is_request && !st.tx_valid && st.pend == 2'b00
      |=> st.pend[$past(rx_idx)] ##1 st.tx_valid)
      else $error("Value request did not queue a command.");
   idle_rx_a: assert property (rx_valid_in && !run && !st.tick |=>
      $stable(st.ack) && $stable(st.disc) && $stable(st.last_rpt))
      else $error("Message handled outside Run mode.");
   run_only_tx_a: assert property ($rose(tx_valid_out) |-> $past(run))
      else $error("Command started outside Run mode.");
   loop_tick_a: assert property (st.tick |-> $past(st.loop_cnt) == LOOP_LAST)
      else $error("Evaluation tick off the loop period.");
   change_now_a: assert property (st.tick && run |=> st.state[0] == $past(pins[0]))
      else $error("Change-now state does not follow oil life.");
   state_enc_a: assert property ($rose(tx_valid_out) |->
      tx_hdr3_out[7] == ((tx_hdr4_out == CODE_LOW_PRESS) ? $past(st.state[1])
                                                         : $past(st.state[0])))
      else $error("State bit does not match the notification state.");

   // Evaluation, ordering and receive bookkeeping; the receive index is taken from the
   // cycle of the message, since idle header lines change right after it.
   low_press_state_a: assert property (st.tick && run |=>
      st.state[1] == $past(lp_qual))
      else $error("Low-pressure state does not follow the qualifier.");
   pend_order_a: assert property (!st.tx_valid && run && st.pend == 2'b11 |=>
      st.tx_valid && st.tx_hdr4 == CODE_CHANGE_NOW)
      else $error("Low pressure sent ahead of a pending change-now command.");
   pend_kept_a: assert property (!run && !st.tx_valid |=> !st.tx_valid &&
      (st.pend & $past(st.pend)) == $past(st.pend))
      else $error("Pending command lost or sent outside Run mode.");
   report_latch_a: assert property (rx_valid_in && run && !rx_hdr0_in[4] && rx_ok
      && is_report |=> st.last_rpt == $past({rx_hdr0_in, rx_hdr2_in, rx_hdr3_in, rx_hdr4_in}))
      else $error("Accepted report was not recorded.");
   report_ack_a: assert property (rx_valid_in && run && !rx_hdr0_in[4] && rx_ok
      && is_report && rx_hdr3_in[STATE_BIT_POS] == st.state[rx_idx]
      |=> st.ack[$past(rx_idx)])
      else $error("Matching report did not set its receipt flag.");
   odd_quiet_a: assert property (rx_valid_in && run && rx_hdr0_in[4] && !st.tick
      |=> (st.pend & ~$past(st.pend)) == 2'b00 && $stable(st.last_rpt))
      else $error("Odd-priority message was acted on.");

   send_cover_c: cover property ($rose(tx_valid_out) ##[1:8] tx_ready_in);
   report_cover_c: cover property (rx_valid_in && run && is_report && rx_ok ##1 |st.ack);
   request_cover_c: cover property (rx_valid_in && run && is_request && rx_ok);
   odd_cover_c: cover property (rx_valid_in && run && rx_hdr0_in[4]);

endmodule

// ---- test/onm_platform_model.sv ----
// Behavioural body platform module: answers commands with reports and asks for values.
module onm_platform_model
   import onm_pkg::*;
#(
   parameter logic [7:0] SRC_ADDR = 8'h40 // Arbitrary source address.
)
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_hdr3_in,
   input wire logic [7:0] tx_hdr4_in,
   input wire logic slow_in,
   input wire logic odd_in,
   input wire logic req_go_in,
   input wire logic [7:0] req_code_in,
   output logic tx_ready_out,
   output logic rx_valid_out,
   output logic [7:0] rx_hdr0_out,
   output logic [7:0] rx_hdr1_out,
   output logic [7:0] rx_hdr2_out,
   output logic [7:0] rx_hdr3_out,
   output logic [7:0] rx_hdr4_out,
   output logic [7:0] rx_payload_byte_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_cnt;
   logic rpt_due;
   logic [7:0] rpt3;
   logic [7:0] rpt4;
   ////////////////////////////////////////////////////////////////////////////////
   // Takes commands, slowly when asked, and remembers what a report must echo.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tx_ready_out <= 1'b0;
         wait_cnt <= 3'd0;
         rpt_due <= 1'b0;
         rpt3 <= 8'h00;
         rpt4 <= 8'h00;
      end
      else
      begin
         tx_ready_out <= 1'b0;
         rpt_due <= 1'b0;
         if (tx_valid_in && tx_ready_out)
         begin
            rpt_due <= 1'b1;
            rpt3 <= tx_hdr3_in;
            rpt4 <= tx_hdr4_in;
            wait_cnt <= 3'd0;
         end
         else if (tx_valid_in && !tx_ready_out)
         begin
            if (wait_cnt >= (slow_in ? 3'd3 : 3'd0))
               tx_ready_out <= 1'b1;
            else
               wait_cnt <= wait_cnt + 3'd1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Sends reports first; a request in the same cycle is dropped, so the bench spaces them.
   // Idle header lines toggle each cycle so stale values can never be mistaken for data.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rx_valid_out <= 1'b0;
         {rx_hdr0_out, rx_hdr1_out, rx_hdr2_out, rx_hdr3_out, rx_hdr4_out} <= 40'h0;
         rx_payload_byte_out <= 8'h00;
      end
      else if (rpt_due)
      begin
         rx_valid_out <= 1'b1;
         rx_hdr0_out <= 8'hAA ^ {3'b000, odd_in, 4'h0};
         rx_hdr1_out <= 8'hEB;
         rx_hdr2_out <= SRC_ADDR;
         rx_hdr3_out <= rpt3;
         rx_hdr4_out <= rpt4;
         rx_payload_byte_out <= 8'h00;
      end
      else if (req_go_in)
      begin
         rx_valid_out <= 1'b1;
         rx_hdr0_out <= 8'hCB ^ {3'b000, odd_in, 4'h0};
         rx_hdr1_out <= 8'hEB;
         rx_hdr2_out <= SRC_ADDR;
         rx_hdr3_out <= 8'h20;
         rx_hdr4_out <= req_code_in;
         rx_payload_byte_out <= 8'h00;
      end
      else
      begin
         rx_valid_out <= 1'b0;
         {rx_hdr0_out, rx_hdr1_out, rx_hdr2_out} <= ~{rx_hdr0_out, rx_hdr1_out, rx_hdr2_out};
         {rx_hdr3_out, rx_hdr4_out} <= ~{rx_hdr3_out, rx_hdr4_out};
         rx_payload_byte_out <= ~rx_payload_byte_out;
      end
   end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the engine-side notification controller.
module tb_top
   import onm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr;
   logic oil = 1'b0, running = 1'b0, fault = 1'b0, sens = 1'b0, swl = 1'b0;
   logic tx_valid, tx_ready, rx_valid;
   logic [7:0] t0, t1, t2, t3, t4, tp, r0, r1, r2, r3, r4, rp;
   logic slow = 1'b0, odd = 1'b0, req_go = 1'b0;
   logic [7:0] req_code = 8'h82;
   int bad_count = 0;
   int n_checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // A short loop keeps the run brief; the quiet and command waits below are sized from it.
   onm_engine_ctrl #(.LOOP_CYCLES(20)) i_onm_engine_ctrl (.ref_clk_in(ref_clk),
      .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .oil_life_reached_in(oil), .engine_running_in(running),
      .press_fault_in(fault), .press_sensor_low_in(sens), .press_switch_low_in(swl),
      .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_hdr0_out(t0), .tx_hdr1_out(t1),
      .tx_hdr2_out(t2), .tx_hdr3_out(t3), .tx_hdr4_out(t4), .tx_payload_byte_out(tp),
      .rx_valid_in(rx_valid), .rx_hdr0_in(r0), .rx_hdr1_in(r1), .rx_hdr2_in(r2),
      .rx_hdr3_in(r3), .rx_hdr4_in(r4), .rx_payload_byte_in(rp));
   onm_platform_model #(.SRC_ADDR(8'h40)) i_onm_platform_model (.ref_clk_in(ref_clk),
      .rst_n_in(rst_n), .tx_valid_in(tx_valid), .tx_hdr3_in(t3), .tx_hdr4_in(t4),
      .slow_in(slow), .odd_in(odd), .req_go_in(req_go), .req_code_in(req_code),
      .tx_ready_out(tx_ready), .rx_valid_out(rx_valid), .rx_hdr0_out(r0), .rx_hdr1_out(r1),
      .rx_hdr2_out(r2), .rx_hdr3_out(r3), .rx_hdr4_out(r4), .rx_payload_byte_out(rp));
   // The clock toggles every half period of 12.5 ns.
   always #12.5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Counts one comparison and reports it at once if it differs.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; it waits for pready as long as it takes, the watchdog being the limit.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk({31'h0, err, rd}, {31'h0, experr, exp});
   endtask
   // Waits for the edge that takes a command and compares the whole message.
   task automatic cmd_chk(input logic [7:0] e3, input logic [7:0] e4);
      int i;
      for (i = 0; i < 80; i++)
      begin
         @(negedge ref_clk);
         if (tx_valid === 1'b1 && tx_ready === 1'b1)
            break;
      end
      chk({tx_valid, tx_ready, t0, t1, t2, t3, t4, tp}, {2'b11, 24'h8A_EA10, e3, e4, 8'h00});
      // Return on the taking edge, so the next stimulus lands on a rising edge.
      @(posedge ref_clk);
   endtask
   // Makes sure no command is offered for a span of cycles.
   task automatic quiet_chk(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) @(negedge ref_clk) seen = seen | (tx_valid !== 1'b0);
      chk({63'h0, seen}, 64'h0);
      @(posedge ref_clk);
   endtask
   // Spaced away from any report so the model never has to drop the request.
   task automatic ask(input logic [7:0] code);
      repeat (6) @(posedge ref_clk);
      req_code <= code;
      req_go <= 1'b1;
      @(posedge ref_clk);
      req_go <= 1'b0;
   endtask
   task automatic test_done;
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // The hang guard allows about fifty times the expected run length.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      test_done();
   end
   // Main sequence of scenarios.
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_chk(8'h00, 32'h0000_0000, 1'b0);
      rd_chk(8'h0C, 32'h0000_0000, 1'b1);
      wr(8'h00, 32'hFFFF_FFFF);
      rd_chk(8'h00, 32'h0000_FF03, 1'b0);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'hFFFF_FFFF);
      rd_chk(8'h04, 32'h0000_0000, 1'b0);
      oil <= 1'b1;
      quiet_chk(60);
      slow <= 1'b1;
      wr(8'h00, 32'h0000_0001);
      cmd_chk(8'hA0, 8'h82);
      slow <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_chk(8'h04, 32'h0000_0005, 1'b0);
      rd_chk(8'h08, 32'hAA40_A082, 1'b0);
      running <= 1'b1;
      sens <= 1'b1;
      cmd_chk(8'hA0, 8'h83);
      fault <= 1'b1;
      cmd_chk(8'h20, 8'h83);
      repeat (6) @(posedge ref_clk);
      rd_chk(8'h04, 32'h0000_000D, 1'b0);
      fault <= 1'b0;
      sens <= 1'b0;
      swl <= 1'b1;
      wr(8'h00, 32'h0000_0003);
      cmd_chk(8'hA0, 8'h83);
      ask(8'h82);
      cmd_chk(8'hA0, 8'h82);
      // The report of the command just taken must pass before odd headers start.
      repeat (4) @(posedge ref_clk);
      odd <= 1'b1;
      ask(8'h83);
      quiet_chk(30);
      odd <= 1'b0;
      rd_chk(8'h04, 32'h0000_010F, 1'b0);
      wr(8'h00, 32'h0000_0000);
      ask(8'h83);
      quiet_chk(30);
      test_done();
   end
endmodule
